// file: hw/scfg_pkg.sv
// package of constants and types for the strap and eeprom configuration loader
package scfg_pkg;
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam int unsigned LOAD_TIME_MS      = 15;                       // config_load_time limit
    localparam int unsigned LOAD_LIMIT_CYC    = CLK_HZ / 1000 * LOAD_TIME_MS;
    localparam int unsigned SCL_HZ            = 100_000;
    localparam int unsigned SCL_QTR_CYC       = CLK_HZ / SCL_HZ / 4;      // quarter scl period
    localparam int unsigned REG_COUNT         = 110;
    localparam int unsigned ADDR_W            = 7;
    localparam logic [6:0]  EEPROM_DEV_ADDR   = 7'h50;
    localparam logic [7:0]  FAMILY_CODE_DFLT  = 8'h5a;                    // arbitrary value
    localparam logic [7:0]  REG_RESET_VAL     = 8'h00;
    localparam int unsigned FIFO_DEPTH        = 8;
    localparam int unsigned FIFO_WIDTH        = 8;
    // dual interface decode
    localparam logic [1:0]  SW_IF_OFF         = 2'h0;
    localparam logic [1:0]  SW_IF_PHY_MII     = 2'h1;
    localparam logic [1:0]  SW_IF_MAC_MII     = 2'h2;
    localparam logic [1:0]  SW_IF_PHY_SNI     = 2'h3;
    localparam logic [2:0]  DUAL_ALL_OFF      = 3'h4;
    // serial bus decode
    localparam logic [1:0]  BUS_TWI_MASTER    = 2'h0;
    localparam logic [1:0]  BUS_RESERVED      = 2'h1;
    localparam logic [1:0]  BUS_SPI_SLAVE     = 2'h2;
    localparam logic [1:0]  BUS_BIST          = 2'h3;

    typedef enum logic [3:0] {
        SCFG_IDLE  = 4'h0,
        SCFG_START = 4'h1,
        SCFG_WBYTE = 4'h3,
        SCFG_WACK  = 4'h2,
        SCFG_RSTRT = 4'h6,
        SCFG_RBYTE = 4'h7,
        SCFG_RACK  = 4'h5,
        SCFG_STOP  = 4'h4,
        SCFG_DONE  = 4'hc
    } scfg_state_t;
endpackage

// file: hw/scfg_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ns
module scfg_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // pointer and count next values
    always_comb begin
        in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
        out_valid_o = (cnt_q != '0);
        out_data_o  = mem_q[rd_q];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wr_d        = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d        = pop  ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce_i) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem_q[wr_q] <= in_data_i;
            end
        end
    end
endmodule // scfg_fifo

// file: hw/scfg_loader.sv
// strap capture and two-wire eeprom configuration loader
`timescale 1ns/1ns
module scfg_loader
    import scfg_pkg::*;
#(
    parameter int unsigned LOAD_LIMIT  = LOAD_LIMIT_CYC,
    parameter logic [7:0]  FAMILY_CODE = FAMILY_CODE_DFLT
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     ce_i,
    input  wire logic                     dual_if_cfg_bit1_i,
    input  wire logic                     dual_if_cfg_bit0_i,
    input  wire logic                     port5_led1_cfg_msb_strap_i,
    input  wire logic                     port5_led2_aging_strap_i,
    output logic                          port5_led1_o,
    output logic                          port5_led1_oe_o,
    output logic                          port5_led2_o,
    output logic                          port5_led2_oe_o,
    input  wire logic                     led1_drive_i,
    input  wire logic                     led2_drive_i,
    input  wire logic                     serial_bus_sel_hi_i,
    input  wire logic                     serial_bus_sel_lo_i,
    output logic [1:0]                    sw_if_mode_o,
    output logic                          p5_if_en_o,
    output logic                          aging_en_o,
    output logic [1:0]                    serial_bus_mode_o,
    output logic                          scl_o,
    output logic                          scl_oe_o,
    output logic                          sda_o,
    output logic                          sda_oe_o,
    input  wire logic                     sda_i,
    output logic                          cfg_wr_valid_o,
    input  wire logic                     cfg_wr_ready_i,
    output logic [scfg_pkg::ADDR_W-1:0]   cfg_wr_addr_o,
    output logic [7:0]                    cfg_wr_data_o,
    output logic                          load_done_o,
    output logic                          load_ok_o,
    output logic                          load_timeout_o
);
    import scfg_pkg::*;

    // read-only or status positions, not written by the load
    function automatic logic is_ro(input logic [ADDR_W-1:0] a);
        is_ro = (a <= 7'd1) || (a[3:0] >= 4'he && a >= 7'd16 && a <= 7'd95);
    endfunction

    // strap pins pass two flops first; they run through reset so the capture sees settled levels
    logic [5:0] strap_m_q, strap_s_q;
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            strap_m_q <= {port5_led1_cfg_msb_strap_i, dual_if_cfg_bit1_i, dual_if_cfg_bit0_i,
                          port5_led2_aging_strap_i, serial_bus_sel_hi_i, serial_bus_sel_lo_i};
            strap_s_q <= strap_m_q;
        end
    end

    // strap capture, pins are inputs while reset is low and until the first clock edge after its release
    logic [5:0] strap_q, strap_d;
    logic       in_rst_q;
    logic [1:0] sda_sync_q;
    always_comb begin
        strap_d = in_rst_q ? strap_s_q : strap_q;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            in_rst_q   <= 1'b1;
            strap_q    <= 6'h00;
            sda_sync_q <= 2'h3;
        end else if (ce_i) begin
            in_rst_q   <= 1'b0;
            strap_q    <= strap_d;                             // last reset-phase sample
            sda_sync_q <= {sda_sync_q[0], sda_i};
        end
    end

    // mode decode
    logic [2:0] dual;
    always_comb begin
        dual              = strap_q[5:3];
        sw_if_mode_o      = (dual == DUAL_ALL_OFF) ? SW_IF_OFF : dual[1:0];
        p5_if_en_o        = dual[2] && (dual != DUAL_ALL_OFF);
        aging_en_o        = strap_q[2];
        serial_bus_mode_o = strap_q[1:0];
        port5_led1_o      = led1_drive_i;
        port5_led2_o      = led2_drive_i;
        port5_led1_oe_o   = rst_b_i && !in_rst_q;
        port5_led2_oe_o   = rst_b_i && !in_rst_q;
    end

    // two-wire master engine
    scfg_state_t st_q, st_d;
    logic [15:0] tick_q, tick_d;
    logic [1:0]  ph_q, ph_d;
    logic [3:0]  bit_q, bit_d;
    logic [8:0]  sh_q, sh_d;
    logic [1:0]  wcnt_q, wcnt_d;
    logic [ADDR_W-1:0] idx_q, idx_d;
    logic [23:0] tmo_q, tmo_d;
    logic        scl_q, scl_d, sda_q, sda_d, ok_q, ok_d, to_q, to_d;
    logic        f_valid, f_ready, step, last;
    logic        sda_s;
    always_comb begin
        sda_s   = sda_sync_q[1];
        st_d    = st_q;
        ph_d    = ph_q;
        bit_d   = bit_q;
        sh_d    = sh_q;
        wcnt_d  = wcnt_q;
        idx_d   = idx_q;
        scl_d   = scl_q;
        sda_d   = sda_q;
        ok_d    = ok_q;
        to_d    = to_q;
        f_valid = 1'b0;
        last    = (idx_q == ADDR_W'(REG_COUNT-1));
        tmo_d   = (st_q == SCFG_DONE) ? tmo_q : tmo_q + 24'h00_0001;
        step    = (tick_q == 16'(SCL_QTR_CYC-1));
        tick_d  = step ? 16'h0000 : tick_q + 16'h0001;
        // leave room for a whole stop sequence so done rises by the limit
        if (tmo_q == 24'(LOAD_LIMIT - 4 * SCL_QTR_CYC - 1) && st_q != SCFG_DONE) begin
            to_d   = 1'b1;
            st_d   = SCFG_STOP;
            ph_d   = 2'h0;
            tick_d = 16'h0000;
        end else if (step) begin
            ph_d = ph_q + 2'h1;
            case (st_q)
                SCFG_IDLE: begin
                    if (strap_q[1:0] == BUS_TWI_MASTER) begin
                        st_d = SCFG_START;
                        ph_d = 2'h0;
                    end else begin
                        st_d = SCFG_DONE;
                    end
                end
                SCFG_START, SCFG_RSTRT: begin
                    // start: sda falls while scl high
                    case (ph_q)
                        2'h0: begin
                            scl_d = 1'b0;
                            sda_d = 1'b1;
                        end
                        2'h1: scl_d = 1'b1;
                        2'h2: sda_d = 1'b0;
                        default: begin
                            scl_d = 1'b0;
                            bit_d = 4'h0;
                            sh_d  = (st_q == SCFG_START) ? {EEPROM_DEV_ADDR, 1'b0, 1'b1}
                                                         : {EEPROM_DEV_ADDR, 1'b1, 1'b1};
                            st_d  = (st_q == SCFG_START) ? SCFG_WBYTE : SCFG_WACK;
                            wcnt_d = (st_q == SCFG_START) ? 2'h0 : 2'h2;
                            if (st_q == SCFG_RSTRT) begin
                                st_d = SCFG_WBYTE;
                            end
                        end
                    endcase
                end
                SCFG_WBYTE: begin
                    // 8 data bits then release for ack
                    case (ph_q)
                        2'h0: sda_d = sh_q[8];
                        2'h1: scl_d = 1'b1;
                        2'h2: ;
                        default: begin
                            scl_d = 1'b0;
                            sh_d  = {sh_q[7:0], 1'b1};
                            bit_d = bit_q + 4'h1;
                            if (bit_q == 4'h8) begin
                                wcnt_d = wcnt_q + 2'h1;
                                bit_d  = 4'h0;
                                if (wcnt_q == 2'h0) begin
                                    sh_d = 9'h001;                     // word address zero
                                end else if (wcnt_q == 2'h1) begin
                                    st_d = SCFG_RSTRT;
                                end else begin
                                    st_d = SCFG_RBYTE;
                                end
                            end
                        end
                    endcase
                end
                SCFG_RBYTE: begin
                    // sample 8 bits, then ack each byte but the last, nack at once after a wrong identity byte
                    case (ph_q)
                        2'h0: sda_d = (bit_q == 4'h8) ? (last || !ok_q) : 1'b1;   // nack ends the read
                        2'h1: scl_d = 1'b1;
                        2'h2: if (bit_q != 4'h8) sh_d = {sh_q[7:0], sda_s};
                        default: begin
                            scl_d = 1'b0;
                            bit_d = bit_q + 4'h1;
                            if (bit_q == 4'h7) begin
                                st_d = SCFG_RACK;
                            end else if (bit_q == 4'h8) begin
                                bit_d = 4'h0;
                                idx_d = idx_q + 7'd1;
                                st_d  = (last || !ok_q) ? SCFG_STOP : SCFG_RBYTE;
                            end
                        end
                    endcase
                end
                SCFG_RACK: begin
                    // byte complete, hand to fifo
                    f_valid = 1'b1;
                    if (f_ready) begin
                        if (idx_q == 7'd0) begin
                            ok_d = (sh_q[7:0] == FAMILY_CODE);
                        end
                        st_d  = SCFG_RBYTE;
                        bit_d = 4'h8;
                    end
                    ph_d = ph_q;
                end
                SCFG_STOP: begin
                    case (ph_q)
                        2'h0: begin
                            scl_d = 1'b0;
                            sda_d = 1'b0;
                        end
                        2'h1: scl_d = 1'b1;
                        2'h2: sda_d = 1'b1;
                        default: st_d = SCFG_DONE;
                    endcase
                end
                SCFG_DONE: ph_d = ph_q;
                default: st_d = SCFG_IDLE;
            endcase
        end
    end
    // engine registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q   <= SCFG_IDLE;
            tick_q <= 16'h0000;
            ph_q   <= 2'h0;
            bit_q  <= 4'h0;
            sh_q   <= 9'h1ff;
            wcnt_q <= 2'h0;
            idx_q  <= 7'd0;
            tmo_q  <= 24'h00_0000;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            ok_q   <= 1'b0;
            to_q   <= 1'b0;
        end else if (ce_i) begin
            st_q   <= st_d;
            tick_q <= tick_d;
            ph_q   <= ph_d;
            bit_q  <= bit_d;
            sh_q   <= sh_d;
            wcnt_q <= wcnt_d;
            idx_q  <= idx_d;
            tmo_q  <= tmo_d;
            scl_q  <= scl_d;
            sda_q  <= sda_d;
            ok_q   <= ok_d;
            to_q   <= to_d;
        end
    end

    // open-drain pins: drive low only
    always_comb begin
        scl_o          = 1'b0;
        sda_o          = 1'b0;
        scl_oe_o       = !scl_q;
        sda_oe_o       = !sda_q;
        load_done_o    = (st_q == SCFG_DONE);
        load_ok_o      = ok_q;
        load_timeout_o = to_q;
    end

    // loaded bytes pass a fifo; first byte and read-only positions dropped
    logic       fin_valid;
    logic [14:0] fout;
    logic       fout_valid;
    always_comb begin
        fin_valid = f_valid && (idx_q == 7'd0 || (ok_q && !is_ro(idx_q)));
    end
    scfg_fifo #(.WIDTH(FIFO_WIDTH + ADDR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .ce_i        (ce_i),
        .in_valid_i  (fin_valid && idx_q != 7'd0),
        .in_ready_o  (f_ready),
        .in_data_i   ({idx_q, sh_q[7:0]}),
        .out_valid_o (fout_valid),
        .out_ready_i (cfg_wr_ready_i),
        .out_data_o  (fout)
    );
    always_comb begin
        cfg_wr_valid_o = fout_valid;
        cfg_wr_addr_o  = fout[14:8];
        cfg_wr_data_o  = fout[7:0];
    end
endmodule // scfg_loader

// file: testbench/scfg_loader_properties.sv
// assertion checker for the configuration loader ports
`timescale 1ns/1ns
module scfg_loader_properties
    import scfg_pkg::*;
#(
    parameter int unsigned LOAD_LIMIT = LOAD_LIMIT_CYC
) (
    input wire logic                        clk_i,
    input wire logic                        rst_b_i,
    input wire logic                        dual_if_cfg_bit1_i,
    input wire logic                        dual_if_cfg_bit0_i,
    input wire logic                        port5_led1_cfg_msb_strap_i,
    input wire logic                        port5_led2_aging_strap_i,
    input wire logic                        port5_led1_oe_o,
    input wire logic                        port5_led2_oe_o,
    input wire logic                        serial_bus_sel_hi_i,
    input wire logic                        serial_bus_sel_lo_i,
    input wire logic [1:0]                  sw_if_mode_o,
    input wire logic                        p5_if_en_o,
    input wire logic                        aging_en_o,
    input wire logic [1:0]                  serial_bus_mode_o,
    input wire logic                        scl_oe_o,
    input wire logic                        sda_oe_o,
    input wire logic                        cfg_wr_valid_o,
    input wire logic                        cfg_wr_ready_i,
    input wire logic [scfg_pkg::ADDR_W-1:0] cfg_wr_addr_o,
    input wire logic [7:0]                  cfg_wr_data_o,
    input wire logic                        load_done_o,
    input wire logic                        load_ok_o
);
    import scfg_pkg::*;
    logic [31:0] wait_q, wait_d;
    logic [6:0]  last_q, last_d;
    wire  [2:0]  dual_w = {port5_led1_cfg_msb_strap_i, dual_if_cfg_bit1_i, dual_if_cfg_bit0_i};
    wire  [1:0]  sw_w   = (dual_w == DUAL_ALL_OFF) ? SW_IF_OFF : dual_w[1:0];
    wire         p5_w   = dual_w[2] && (dual_w[1:0] != 2'h0);
    wire  [1:0]  bus_w  = {serial_bus_sel_hi_i, serial_bus_sel_lo_i};
    wire         ro_w   = cfg_wr_addr_o inside {0, 1, 30, 31, 46, 47, 62, 63, 78, 79, 94, 95};
    // open-load cycle count and last index handed over
    always_comb begin
        wait_d = (!rst_b_i || load_done_o) ? 32'h0000_0000 : wait_q + 32'h0000_0001;
        last_d = !rst_b_i ? 7'h01 : (cfg_wr_valid_o && cfg_wr_ready_i) ? cfg_wr_addr_o : last_q;
    end
    // register the helpers
    always_ff @(posedge clk_i) begin
        wait_q <= wait_d;
        last_q <= last_d;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_release;
        $rose(rst_b_i);
    endsequence
    sequence s_taken;
        cfg_wr_valid_o && cfg_wr_ready_i;
    endsequence
    a_led_pins_input: assert property (s_release |-> !port5_led1_oe_o && !port5_led2_oe_o)
        else $error("led pins driven during reset");
    a_led_pins_output: assert property (s_release |-> ##2 port5_led1_oe_o && port5_led2_oe_o)
        else $error("led pins not driven after reset");
    a_aging_strap: assert property (s_release |=> aging_en_o == $past(port5_led2_aging_strap_i))
        else $error("aging enable differs from strap");
    a_switch_if_mode: assert property (s_release |=> sw_if_mode_o == $past(sw_w))
        else $error("switch interface mode decode wrong");
    a_port5_if_mode: assert property (s_release |=> p5_if_en_o == $past(p5_w))
        else $error("port 5 interface decode wrong");
    a_serial_bus_mode: assert property (s_release |=> serial_bus_mode_o == $past(bus_w))
        else $error("serial bus mode decode wrong");
    a_no_early_bus: assert property (s_release |-> (!scl_oe_o && !sda_oe_o)[*8])
        else $error("bus activity right at reset release");
    a_quiet_modes: assert property ($past(rst_b_i) && serial_bus_mode_o != BUS_TWI_MASTER
        |-> !scl_oe_o && !sda_oe_o) else $error("bus driven outside master mode");
    a_nonmaster_done: assert property (s_release ##2 serial_bus_mode_o != BUS_TWI_MASTER
        |-> ##[0:300] load_done_o) else $error("done missing outside master mode");
    a_load_bound: assert property (wait_q <= LOAD_LIMIT)
        else $error("load ran past its time limit");
    a_addr_ascend: assert property (s_taken |-> cfg_wr_addr_o > last_q && !ro_w)
        else $error("write index out of order or read-only");
    a_word_holds: assert property (cfg_wr_valid_o && !cfg_wr_ready_i
        |=> cfg_wr_valid_o && $stable(cfg_wr_addr_o) && $stable(cfg_wr_data_o)) else $error("word dropped");
    a_reject_quiet: assert property (load_done_o && !load_ok_o |-> !cfg_wr_valid_o)
        else $error("data forwarded after a rejected image");
endmodule // scfg_loader_properties
bind scfg_loader scfg_loader_properties #(.LOAD_LIMIT(LOAD_LIMIT)) chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .dual_if_cfg_bit1_i(dual_if_cfg_bit1_i), .dual_if_cfg_bit0_i(dual_if_cfg_bit0_i),
    .port5_led1_cfg_msb_strap_i(port5_led1_cfg_msb_strap_i), .port5_led2_aging_strap_i(port5_led2_aging_strap_i),
    .port5_led1_oe_o(port5_led1_oe_o), .port5_led2_oe_o(port5_led2_oe_o), .serial_bus_sel_hi_i(serial_bus_sel_hi_i),
    .serial_bus_sel_lo_i(serial_bus_sel_lo_i), .sw_if_mode_o(sw_if_mode_o), .p5_if_en_o(p5_if_en_o),
    .aging_en_o(aging_en_o), .serial_bus_mode_o(serial_bus_mode_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
    .cfg_wr_valid_o(cfg_wr_valid_o), .cfg_wr_ready_i(cfg_wr_ready_i), .cfg_wr_addr_o(cfg_wr_addr_o),
    .cfg_wr_data_o(cfg_wr_data_o), .load_done_o(load_done_o), .load_ok_o(load_ok_o));

// file: testbench/scfg_eeprom_model.sv
// behavioural two-wire configuration eeprom on a pulled-up bus
`timescale 1ns/1ns
module scfg_eeprom_model (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [7:0] first_i,
    output logic            sda_pull_o
);
    logic [7:0] sh;
    logic [3:0] bc;
    logic [6:0] ptr;
    logic       act, rdm, rdgo, nb;
    // image: identity byte first, then a fixed pattern for every register
    wire  [7:0] byte_w = (ptr == 7'h00) ? first_i : (8'ha5 ^ {1'b0, ptr});
    initial begin
        act = 1'b0;
        sda_pull_o = 1'b0;
    end
    // start condition opens a transfer, stop ends it
    always @(negedge sda_i) if (scl_i) begin
        act = 1'b1;
        bc = 4'hf;
        nb = 1'b0;
        rdm = 1'b0;
        rdgo = 1'b0;
    end
    always @(posedge sda_i) if (scl_i) act = 1'b0;
    // sample written bits; on a read ack slot step on or quit at a nack
    always @(posedge scl_i) if (act) begin
        if (bc < 4'h8) sh = {sh[6:0], sda_i};
        else if (rdm) begin
            ptr = ptr + 7'h01;
            if (sda_i) act = 1'b0;
        end
    end
    // move to the next bit and set the data line while the clock is low
    always @(negedge scl_i) if (act) begin
        if (bc == 4'h8) begin
            bc = 4'h0;
            nb = 1'b1;
            rdm = rdgo;
        end else bc = bc + 4'h1;
        if (bc == 4'h8) begin
            if (!rdm && !nb) rdgo = sh[0];
            if (!rdm && nb) ptr = sh[6:0];
            sda_pull_o = !rdm; // ack written bytes, leave read acks to the master
        end else sda_pull_o = rdm && !byte_w[3'h7 - bc[2:0]];
    end
endmodule // scfg_eeprom_model

// file: testbench/scfg_loader_bench.sv
// self-checking bench for the strap capture and eeprom loader
`timescale 1ns/1ns
module scfg_loader_bench;
    import scfg_pkg::*;
    logic       clk_i = 1'b0, rst_b_i = 1'b0, aging = 1'b1, drv1 = 1'b0, drv2 = 1'b0, ready = 1'b1;
    logic [2:0] dual = 3'h0;
    logic [1:0] bus = 2'h0;
    logic [7:0] first = 8'h00;
    logic       led1_o, led1_oe, led2_o, led2_oe, p5_en, ag_en, scl_oe, sda_oe, pull, valid, done, ok, tmo;
    logic [1:0] sw_mode, bus_mode;
    logic [6:0] addr;
    logic [7:0] data;
    int         fail_count = 0, samples_checked = 0, n, q;
    logic       last_scl;
    wire        scl_w = !scl_oe;
    wire        sda_w = !(sda_oe || pull);
    // rows: dual[11:9] aging[8] bus[7:6] | sw[5:4] p5[3] aging[2] bus[1:0]
    logic [11:0] rows [8] = '{12'h000, 12'h355, 12'h4a2, 12'h7f7, 12'h800, 12'hb5d, 12'hcaa, 12'hfff};
    always #10 clk_i = ~clk_i;
    scfg_loader #(.LOAD_LIMIT(200000)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
        .dual_if_cfg_bit1_i(dual[1]), .dual_if_cfg_bit0_i(dual[0]), .port5_led1_cfg_msb_strap_i(dual[2]),
        .port5_led2_aging_strap_i(aging), .port5_led1_o(led1_o), .port5_led1_oe_o(led1_oe),
        .port5_led2_o(led2_o), .port5_led2_oe_o(led2_oe), .led1_drive_i(drv1), .led2_drive_i(drv2),
        .serial_bus_sel_hi_i(bus[1]), .serial_bus_sel_lo_i(bus[0]), .sw_if_mode_o(sw_mode),
        .p5_if_en_o(p5_en), .aging_en_o(ag_en), .serial_bus_mode_o(bus_mode), .scl_o(), .scl_oe_o(scl_oe),
        .sda_o(), .sda_oe_o(sda_oe), .sda_i(sda_w), .cfg_wr_valid_o(valid), .cfg_wr_ready_i(ready),
        .cfg_wr_addr_o(addr), .cfg_wr_data_o(data), .load_done_o(done), .load_ok_o(ok), .load_timeout_o(tmo));
    scfg_eeprom_model eeprom_u (.scl_i(scl_w), .sda_i(sda_w), .first_i(first), .sda_pull_o(pull));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // power-up style reset pulse, held low for 8 clock cycles
    task automatic pulse_reset();
        rst_b_i = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
    endtask
    // watchdog against a hung load
    initial begin
        #2_000_000;
        fail_count++;
        summarize();
    end
    initial begin
        @(negedge clk_i);
        // strap decode for every dual and serial bus setting
        for (int r = 0; r < 8; r++) begin
            {dual, aging, bus} = rows[r][11:6];
            drv1 = rows[r][0];
            drv2 = !rows[r][0];
            pulse_reset();
            repeat (200) @(negedge clk_i);
            check(8'(sw_mode), 8'(rows[r][5:4]));
            check(8'(p5_en), 8'(rows[r][3]));
            check(8'(ag_en), 8'(rows[r][2]));
            check(8'(bus_mode), 8'(rows[r][1:0]));
            check(8'({led1_oe, led2_oe, led1_o, led2_o}), 8'({2'b11, drv1, drv2}));
            check(8'(done), 8'(bus != BUS_TWI_MASTER));
        end
        // wrong identity byte: nothing loaded
        {dual, aging, bus} = 6'h04;
        pulse_reset();
        for (n = 0; n < 30000 && done !== 1'b1; n++) @(negedge clk_i);
        check(8'({done, ok, valid, tmo}), 8'h08);
        // matching image with the consumer stalled until the bus stops
        first = FAMILY_CODE_DFLT;
        ready = 1'b0;
        pulse_reset();
        for (n = 0; n < 40000 && valid !== 1'b1; n++) @(negedge clk_i);
        q = 0;
        for (n = 0; n < 60000 && q < 1000; n++) begin
            @(negedge clk_i);
            q = (scl_w === last_scl) ? q + 1 : 0;
            last_scl = scl_w;
        end
        check(8'(q), 8'(1000));
        ready = 1'b1;
        for (int a = 2; a < 10; a++) begin
            for (n = 0; n < 10000 && valid !== 1'b1; n++) @(negedge clk_i);
            check(8'(addr), 8'(a));
            check(data, 8'ha5 ^ 8'(a));
            @(negedge clk_i);
        end
        check(8'({ok, tmo}), 8'h02);
        // reset in mid-load releases the bus and the led pins
        repeat (3000) @(negedge clk_i);
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check(8'({scl_oe, sda_oe, done, valid, led1_oe, led2_oe}), 8'h00);
        rst_b_i = 1'b1;
        repeat (20) @(negedge clk_i);
        summarize();
    end
endmodule // scfg_loader_bench
